//--- pkg/vgsc_regs.vh
// constants for the vga gain serial control block
`ifndef VGSC_REGS_VH
`define VGSC_REGS_VH
`define VGSC_WORD_BITS 16
`define VGSC_CNT_W 5
`define VGSC_CNT_ZERO 5'h00
`define VGSC_CNT_ONE 5'h01
`define VGSC_CNT_FULL 5'h10
`define VGSC_CNT_OVER 5'h11
`define VGSC_RW_BIT 15
`define VGSC_FA_HI 7
`define VGSC_FA_LO 6
`define VGSC_GAIN_HI 5
`define VGSC_GAIN_LO 0
`define VGSC_WORD_RST 16'h003f
`define VGSC_GAIN_RST 6'h3f
`define VGSC_GAIN_MIN_CODE 6'h3f
`define VGSC_GAIN_MAX_CODE 6'h00
`define VGSC_HDB_TOP 8'h28
`define VGSC_ATK_BASE 7'h04
`define VGSC_UD_BASE 6'h01
`define VGSC_MODE_PAR 2'h0
`define VGSC_MODE_SER 2'h1
`define VGSC_MODE_UD 2'h2
`endif

//--- core/vgsc_chan.v
// one amplifier channel: gain code source selection and stored serial word
`timescale 1ns/1ps
`include "vgsc_regs.vh"
module vgsc_chan (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire [1:0] mode_i,
  input wire ser_wr_i,
  input wire [15:0] ser_word_i,
  input wire [5:0] par_gain_i,
  input wire par_latch_i,
  input wire ud_clk_i,
  input wire ud_dat_i,
  input wire [1:0] ud_step_i,
  output wire [15:0] stored_word_o,
  output wire [5:0] base_gain_o,
  output wire [1:0] attack_step_o
);
  reg [15:0] word_q;
  reg [5:0] par_q;
  reg [5:0] ud_q;
  reg ud_clk_prev_q;
  reg [5:0] base_q;
  wire [1:0] iface;
  wire [5:0] ud_inc;
  wire [6:0] ud_up;
  wire [6:0] ud_dn;

  function [1:0] iface_of;
    input [1:0] mode;
    begin
      if (mode == `VGSC_MODE_PAR)
        iface_of = `VGSC_MODE_PAR;
      else if (mode == `VGSC_MODE_SER)
        iface_of = `VGSC_MODE_SER;
      else
        iface_of = `VGSC_MODE_UD;
    end
  endfunction

  assign iface = iface_of(mode_i); // [RULE12]
  assign ud_inc = `VGSC_UD_BASE << ud_step_i;
  // gain up means a smaller code; both ends clamp
  assign ud_up = {1'b0, ud_q} - {1'b0, ud_inc};
  assign ud_dn = {1'b0, ud_q} + {1'b0, ud_inc};

  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      word_q <= `VGSC_WORD_RST;
      par_q <= `VGSC_GAIN_RST;
      ud_q <= `VGSC_GAIN_RST;
      ud_clk_prev_q <= 1'b0;
      base_q <= `VGSC_GAIN_RST;
    end
    else
    begin
      ud_clk_prev_q <= ud_clk_i;
      // ignored bits are kept only so readback returns the written pattern
      if (ser_wr_i && iface == `VGSC_MODE_SER) // [RULE11]
      begin
        word_q <= ser_word_i; // [RULE3] [RULE4] [RULE5]
        word_q[`VGSC_RW_BIT] <= 1'b0;
      end
      if (iface == `VGSC_MODE_PAR && !par_latch_i)
        par_q <= par_gain_i; // [RULE11]
      if (iface == `VGSC_MODE_UD && ud_clk_i != ud_clk_prev_q) // [RULE11]
      begin
        if (ud_dat_i)
          ud_q <= ud_up[6] ? `VGSC_GAIN_MAX_CODE : ud_up[5:0]; // [RULE10]
        else if (ud_dn > {1'b0, `VGSC_GAIN_MIN_CODE})
          ud_q <= `VGSC_GAIN_MIN_CODE;
        else
          ud_q <= ud_dn[5:0];
      end
      case (iface)
        `VGSC_MODE_PAR: base_q <= par_q; // [RULE11]
        `VGSC_MODE_SER: base_q <= word_q[`VGSC_GAIN_HI:`VGSC_GAIN_LO];
        default: base_q <= ud_q;
      endcase
    end
  end

  assign stored_word_o = word_q;
  assign base_gain_o = base_q;
  assign attack_step_o = word_q[`VGSC_FA_HI:`VGSC_FA_LO]; // [RULE4]
endmodule // vgsc_chan

//--- core/vgsc_top.v
// dual channel vga gain control with 16-bit serial word interface
//
// Function
// (RULE1) code 0 is +20 dB, 63 is -11.5
// (RULE2) one 16-bit word per select-low frame
// (RULE3) write bit low loads six gain bits
// (RULE4) written step bits select attack step
// (RULE5) ignored bit positions change nothing
// (RULE6) write bit high requests readback only
// (RULE7) next frame drives stored word out
// (RULE8) after readback, device returns to write
// (RULE9) power-up input low powers channel down
// (RULE10) half dB per code, coarser via steps
// (RULE11) only selected interface changes the gain
// (RULE12) 00 parallel, 01 serial, else up/down
// (RULE13) attack input reduces gain by step; code does so in serial mode only
// (RULE14) both selects low write both channels
// (RULE15) sample on rising edge, apply at frame end
// (RULE16) attack saturates at minimum gain code
`timescale 1ns/1ps
`include "vgsc_regs.vh"
module vgsc_top (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire sclk_i,
  input wire chan_a_select_n_i,
  input wire chan_b_select_n_i,
  input wire sdio_i,
  input wire chan_a_attack_trigger_i,
  input wire chan_b_attack_trigger_i,
  input wire chan_a_power_up_i,
  input wire chan_b_power_up_i,
  input wire iface_select0_i,
  input wire iface_select1_i,
  input wire [5:0] par_gain_a_i,
  input wire [5:0] par_gain_b_i,
  input wire par_latch_a_i,
  input wire par_latch_b_i,
  input wire updn_clk_a_i,
  input wire updn_dat_a_i,
  input wire updn_clk_b_i,
  input wire updn_dat_b_i,
  input wire [1:0] updn_step_i,
  output wire sdio_o,
  output wire sdio_oe_o,
  output wire [5:0] gain_code_a_o,
  output wire [5:0] gain_code_b_o,
  output wire [7:0] gain_hdb_a_o,
  output wire [7:0] gain_hdb_b_o,
  output wire chan_a_active_o,
  output wire chan_b_active_o
);
  localparam PIN_W = 30;
  localparam NCH = 2;
  // selects park high in reset, so release shows no false frame edge
  localparam [PIN_W-1:0] PIN_IDLE = {1'b0, 1'b1, 1'b1, {(PIN_W-3){1'b0}}};

  // every pin is asynchronous to clk_sys_i, two flops each
  wire [PIN_W-1:0] pin_raw;
  reg [PIN_W-1:0] meta_q;
  reg [PIN_W-1:0] sync_q;

  assign pin_raw = {sclk_i, chan_a_select_n_i, chan_b_select_n_i, sdio_i,
                    chan_b_attack_trigger_i, chan_a_attack_trigger_i,
                    chan_b_power_up_i, chan_a_power_up_i,
                    iface_select1_i, iface_select0_i,
                    par_gain_b_i, par_gain_a_i,
                    par_latch_b_i, par_latch_a_i,
                    updn_dat_b_i, updn_clk_b_i, updn_dat_a_i, updn_clk_a_i,
                    updn_step_i};

  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_q <= PIN_IDLE;
      sync_q <= PIN_IDLE;
    end
    else
    begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  wire sclk_s;
  wire csa_n_s;
  wire csb_n_s;
  wire sdio_s;
  wire [NCH-1:0] attack_s;
  wire [NCH-1:0] power_s;
  wire [1:0] mode_s;
  wire [11:0] par_gain_s;
  wire [NCH-1:0] par_latch_s;
  wire [3:0] updn_s;
  wire [1:0] updn_step_s;

  assign {sclk_s, csa_n_s, csb_n_s, sdio_s, attack_s, power_s, mode_s,
          par_gain_s, par_latch_s, updn_s, updn_step_s} = sync_q;

  // serial clock edges found on the synchronised level
  reg sclk_prev_q;
  wire sclk_rise;
  wire sclk_fall;

  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  // frame tracking
  wire frame;
  reg frame_q;
  wire frame_start;
  wire frame_stop;
  wire ser_mode;

  assign frame = ~csa_n_s | ~csb_n_s; // [RULE2]
  assign frame_start = frame & ~frame_q;
  assign frame_stop = ~frame & frame_q;
  assign ser_mode = (mode_s == `VGSC_MODE_SER);

  reg taken_q;
  reg sel_a_q;
  reg sel_b_q;
  reg [`VGSC_CNT_W-1:0] bit_cnt_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg rd_mode_q;
  reg rd_pend_q;
  reg rd_chan_b_q;
  reg sdio_q;
  reg sdio_oe_q;
  reg [NCH-1:0] wr_q;
  reg [15:0] wr_word_q;

  wire [15:0] stored_a;
  wire [15:0] stored_b;
  wire rd_hit;

  // readback runs only on the channel that took the request
  assign rd_hit = rd_pend_q & (rd_chan_b_q ? ~csb_n_s : ~csa_n_s); // [RULE14]

  always @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sclk_prev_q <= 1'b0;
      frame_q <= 1'b0;
      taken_q <= 1'b0;
      sel_a_q <= 1'b0;
      sel_b_q <= 1'b0;
      bit_cnt_q <= `VGSC_CNT_ZERO;
      rx_q <= {16{1'b0}};
      tx_q <= {16{1'b0}};
      rd_mode_q <= 1'b0;
      rd_pend_q <= 1'b0;
      rd_chan_b_q <= 1'b0;
      sdio_q <= 1'b0;
      sdio_oe_q <= 1'b0;
      wr_q <= {NCH{1'b0}};
      wr_word_q <= {16{1'b0}};
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      frame_q <= frame;
      wr_q <= {NCH{1'b0}};
      if (frame_start)
      begin
        // frames that open outside serial mode are not taken
        taken_q <= ser_mode;
        sel_a_q <= ~csa_n_s;
        sel_b_q <= ~csb_n_s;
        bit_cnt_q <= `VGSC_CNT_ZERO;
        if (ser_mode && rd_hit)
        begin
          rd_mode_q <= 1'b1; // [RULE7]
          sdio_oe_q <= 1'b1;
          sdio_q <= rd_chan_b_q ? stored_b[15] : stored_a[15];
          tx_q <= (rd_chan_b_q ? stored_b : stored_a) << 1;
        end
      end
      else if (frame && taken_q)
      begin
        if (sclk_rise)
        begin
          if (bit_cnt_q != `VGSC_CNT_OVER)
            bit_cnt_q <= bit_cnt_q + `VGSC_CNT_ONE;
          if (!rd_mode_q)
            rx_q <= {rx_q[14:0], sdio_s}; // [RULE15]
        end
        if (sclk_fall && rd_mode_q)
        begin
          sdio_q <= tx_q[15]; // [RULE7]
          tx_q <= {tx_q[14:0], 1'b0};
        end
      end
      else if (frame_stop && taken_q)
      begin
        taken_q <= 1'b0;
        if (rd_mode_q)
        begin
          // any end of the readback frame drops back to write
          rd_mode_q <= 1'b0; // [RULE8]
          rd_pend_q <= 1'b0;
          sdio_oe_q <= 1'b0;
          sdio_q <= 1'b0;
        end
        else if (bit_cnt_q == `VGSC_CNT_FULL) // [RULE2] [RULE15]
        begin
          if (rx_q[`VGSC_RW_BIT])
          begin
            // request only, gain stays as is; channel a wins if both low
            rd_pend_q <= 1'b1; // [RULE6]
            rd_chan_b_q <= ~sel_a_q;
          end
          else
          begin
            wr_q <= {sel_b_q, sel_a_q}; // [RULE14] [RULE3]
            wr_word_q <= rx_q;
          end
        end
      end
    end
  end

  // channels
  wire [15:0] stored_w [0:NCH-1];
  wire [5:0] base_w [0:NCH-1];
  wire [1:0] step_w [0:NCH-1];

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1)
    begin : g_chan
      vgsc_chan u_chan (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .mode_i(mode_s),
        .ser_wr_i(wr_q[ch]),
        .ser_word_i(wr_word_q),
        .par_gain_i(par_gain_s[ch*6 +: 6]),
        .par_latch_i(par_latch_s[ch]),
        .ud_clk_i(updn_s[ch*2]),
        .ud_dat_i(updn_s[ch*2+1]),
        .ud_step_i(updn_step_s),
        .stored_word_o(stored_w[ch]),
        .base_gain_o(base_w[ch]),
        .attack_step_o(step_w[ch])
      );
    end
  endgenerate

  assign stored_a = stored_w[0];
  assign stored_b = stored_w[1];

  // attack steps of 2/4/8/16 dB are 4/8/16/32 codes
  function [6:0] attack_codes;
    input [1:0] step;
    begin
      attack_codes = `VGSC_ATK_BASE << step; // [RULE13]
    end
  endfunction

  function [5:0] attack_gain;
    input [5:0] code;
    input [1:0] step;
    input fire;
    reg [7:0] sum;
    begin
      sum = {2'b00, code} + {1'b0, attack_codes(step)};
      if (!fire)
        attack_gain = code;
      else if (sum > {2'b00, `VGSC_GAIN_MIN_CODE})
        attack_gain = `VGSC_GAIN_MIN_CODE; // [RULE16]
      else
        attack_gain = sum[5:0];
    end
  endfunction

  generate
    for (ch = 0; ch < NCH; ch = ch + 1)
    begin : g_out
      wire [5:0] eff;
      reg [5:0] code_q;
      reg [7:0] hdb_q;
      reg active_q;
      // attack applies only in serial mode, where its step is held
      assign eff = attack_gain(base_w[ch], step_w[ch],
                               attack_s[ch] & ser_mode); // [RULE13]
      always @(posedge clk_sys_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          code_q <= `VGSC_GAIN_RST;
          hdb_q <= `VGSC_HDB_TOP - {2'b00, `VGSC_GAIN_RST};
          active_q <= 1'b0;
        end
        else
        begin
          code_q <= eff;
          // half dB units, two's complement: 40 - code
          hdb_q <= `VGSC_HDB_TOP - {2'b00, eff}; // [RULE1] [RULE10]
          active_q <= power_s[ch]; // [RULE9]
        end
      end
    end
  endgenerate

  assign sdio_o = sdio_q;
  assign sdio_oe_o = sdio_oe_q;
  assign gain_code_a_o = g_out[0].code_q;
  assign gain_code_b_o = g_out[1].code_q;
  assign gain_hdb_a_o = g_out[0].hdb_q;
  assign gain_hdb_b_o = g_out[1].hdb_q;
  assign chan_a_active_o = g_out[0].active_q;
  assign chan_b_active_o = g_out[1].active_q;
endmodule // vgsc_top

//--- verification/vgsc_props_properties.sv
// concurrent checks on the vgsc_top ports
`timescale 1ns/1ps
module vgsc_props (
  input wire clk_sys_i,
  input wire rstn_i,
  input wire chan_a_select_n_i,
  input wire chan_b_select_n_i,
  input wire chan_a_attack_trigger_i,
  input wire chan_a_power_up_i,
  input wire chan_b_power_up_i,
  input wire iface_select0_i,
  input wire iface_select1_i,
  input wire sdio_oe_o,
  input wire [5:0] gain_code_a_o,
  input wire [5:0] gain_code_b_o,
  input wire [7:0] gain_hdb_a_o,
  input wire [7:0] gain_hdb_b_o,
  input wire chan_a_active_o,
  input wire chan_b_active_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  wire ser = {iface_select1_i, iface_select0_i} == 2'b01;
  reg atk_q;
  reg [3:0] quiet_q;
  always @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      atk_q <= 1'b0;
    else
      atk_q <= chan_a_attack_trigger_i;
  // frames on a with nothing else moving; margin covers sync latency
  always @(posedge clk_sys_i or negedge rstn_i)
    if (!rstn_i)
      quiet_q <= 4'h0;
    else if (chan_a_select_n_i || !ser || atk_q != chan_a_attack_trigger_i)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hf)
      quiet_q <= quiet_q + 4'h1;
  a_hdb_a_map:
  assert property (gain_hdb_a_o == 8'h28 - {2'b00, gain_code_a_o}
    || gain_hdb_a_o == 8'h28 - {2'b00, $past(gain_code_a_o)}) else $error("gain a hdb wrong");
  a_hdb_b_map:
  assert property (gain_hdb_b_o == 8'h28 - {2'b00, gain_code_b_o}
    || gain_hdb_b_o == 8'h28 - {2'b00, $past(gain_code_b_o)}) else $error("gain b hdb wrong");
  a_gain_mid_frame:
  assert property (quiet_q >= 4'h8 |-> $stable(gain_code_a_o)) else $error("gain moved in frame");
  a_pwr_a_on:
  assert property (chan_a_power_up_i [*6] |-> chan_a_active_o) else $error("chan a not active");
  a_pwr_b_off:
  assert property (!chan_b_power_up_i [*6] |-> !chan_b_active_o) else $error("chan b active");
  a_oe_idle_off:
  assert property ((chan_a_select_n_i && chan_b_select_n_i) [*8] |-> !sdio_oe_o)
    else $error("pin driven outside frame");
  a_oe_needs_sel:
  assert property ($rose(sdio_oe_o) |-> !(chan_a_select_n_i && chan_b_select_n_i))
    else $error("pin driven without select");
  a_attack_min_step:
  assert property ((ser && chan_a_attack_trigger_i) [*8] |-> gain_code_a_o >= 6'h04)
    else $error("attack step missing");
endmodule // vgsc_props
bind vgsc_top vgsc_props u_props (
  .clk_sys_i(clk_sys_i),
  .rstn_i(rstn_i),
  .chan_a_select_n_i(chan_a_select_n_i),
  .chan_b_select_n_i(chan_b_select_n_i),
  .chan_a_attack_trigger_i(chan_a_attack_trigger_i),
  .chan_a_power_up_i(chan_a_power_up_i),
  .chan_b_power_up_i(chan_b_power_up_i),
  .iface_select0_i(iface_select0_i),
  .iface_select1_i(iface_select1_i),
  .sdio_oe_o(sdio_oe_o),
  .gain_code_a_o(gain_code_a_o),
  .gain_code_b_o(gain_code_b_o),
  .gain_hdb_a_o(gain_hdb_a_o),
  .gain_hdb_b_o(gain_hdb_b_o),
  .chan_a_active_o(chan_a_active_o),
  .chan_b_active_o(chan_b_active_o)
);

//--- verification/vgsc_host_model.sv
// host model driving the serial gain-control link
`timescale 1ns/1ps
module vgsc_host_model (
  input wire clk_sys_i,
  input wire sdio_i,
  output reg sclk_o,
  output reg csa_n_o,
  output reg csb_n_o,
  output reg sdo_o,
  output reg sdo_en_o,
  output reg [15:0] rd_q
);
  initial
  begin
    sclk_o = 1'b0;
    csa_n_o = 1'b1;
    csb_n_o = 1'b1;
    sdo_o = 1'b0;
    sdo_en_o = 1'b1;
    rd_q = 16'h0000;
  end
  // sclk parked low between frames; msb first, data moves while sclk low
  task automatic xfer(input [1:0] cs_n, input [15:0] w, input int nbits, input bit rd);
    int i;
    {csb_n_o, csa_n_o} <= cs_n;
    sdo_en_o <= !rd;
    for (i = 15; i > 15 - nbits; i--)
    begin
      sdo_o <= rd ? ~sdo_o : w[i];
      repeat (8) @(posedge clk_sys_i);
      sclk_o <= 1'b1;
      rd_q[i] <= sdio_i;
      repeat (8) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
    end
    repeat (8) @(posedge clk_sys_i);
    {csb_n_o, csa_n_o} <= 2'b11;
    sdo_en_o <= 1'b1;
    repeat (10) @(posedge clk_sys_i);
  endtask
endmodule // vgsc_host_model

//--- verification/vgsc_top_tb.sv
// self-checking bench for vgsc_top
`timescale 1ns/1ps
module vgsc_top_tb;
  reg clk_sys_i = 1'b0;
  reg rstn_i = 1'b0;
  reg atk_a = 1'b0, atk_b = 1'b0, pw_a = 1'b0, pw_b = 1'b0;
  reg pl_a = 1'b0, pl_b = 1'b0, uc_a = 1'b0, ud_a = 1'b0, uc_b = 1'b0, ud_b = 1'b0;
  reg [1:0] md = 2'b00, us = 2'b00;
  reg [5:0] pg_a = 6'h00, pg_b = 6'h00;
  reg [31:0] seed = 32'he5dc_69a5;
  reg [31:0] nz;
  reg [17:0] exp_q[$];
  int n_errors = 0, n_compared = 0;
  wire sclk, csa_n, csb_n, h_d, h_en, sdo, soe, act_a, act_b;
  wire [5:0] gc_a, gc_b;
  wire [7:0] hd_a, hd_b;
  // released pin shows a moving pattern, never a held level
  wire sdio_w = soe ? sdo : h_en ? h_d : ~h_d;
  initial
    forever #5 clk_sys_i = ~clk_sys_i;
  vgsc_host_model u_host (.clk_sys_i(clk_sys_i), .sdio_i(sdio_w), .sclk_o(sclk),
    .csa_n_o(csa_n), .csb_n_o(csb_n), .sdo_o(h_d), .sdo_en_o(h_en), .rd_q());
  vgsc_top uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sclk_i(sclk),
    .chan_a_select_n_i(csa_n), .chan_b_select_n_i(csb_n), .sdio_i(sdio_w),
    .chan_a_attack_trigger_i(atk_a), .chan_b_attack_trigger_i(atk_b),
    .chan_a_power_up_i(pw_a), .chan_b_power_up_i(pw_b), .iface_select0_i(md[0]),
    .iface_select1_i(md[1]), .par_gain_a_i(pg_a), .par_gain_b_i(pg_b), .par_latch_a_i(pl_a),
    .par_latch_b_i(pl_b), .updn_clk_a_i(uc_a), .updn_dat_a_i(ud_a), .updn_clk_b_i(uc_b),
    .updn_dat_b_i(ud_b), .updn_step_i(us), .sdio_o(sdo), .sdio_oe_o(soe),
    .gain_code_a_o(gc_a), .gain_code_b_o(gc_b), .gain_hdb_a_o(hd_a), .gain_hdb_b_o(hd_b),
    .chan_a_active_o(act_a), .chan_b_active_o(act_b));
  function automatic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed[15:0];
  endfunction
  // half dB gain, +20 dB at code zero, next to the code itself
  function automatic [15:0] gexp(input [5:0] c);
    gexp = {8'h28 - {2'b00, c}, 2'b00, c};
  endfunction
  task automatic expect_val(input [1:0] sel, input [15:0] v);
    exp_q.push_back({sel, v});
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // unselected interfaces toggle at random while the serial one rules
  always @(posedge clk_sys_i)
    if (md == 2'b01)
    begin
      nz = {rnd(), rnd()};
      {pg_a, pg_b, pl_a, pl_b, uc_a, ud_a, uc_b, ud_b, us} <= nz[19:0];
    end
  always @(negedge clk_sys_i)
    while (exp_q.size() > 0)
    begin : mon
      reg [17:0] e;
      reg [15:0] act;
      e = exp_q.pop_front();
      case (e[17:16])
        2'd0: act = {hd_a, 2'b00, gc_a};
        2'd1: act = {hd_b, 2'b00, gc_b};
        2'd2: act = u_host.rd_q;
        default: act = {14'h0000, act_b, act_a};
      endcase
      n_compared++;
      if (act !== e[15:0])
      begin
        n_errors++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e[15:0], act);
      end
    end
  initial
  begin
    #400000;
    n_errors++;
    wrap_up();
  end
  initial
  begin : main
    reg [15:0] r, w, wa, wb;
    reg [5:0] g;
    int s, t;
    @(posedge clk_sys_i);
    expect_val(2'd0, gexp(6'h3f));
    expect_val(2'd1, gexp(6'h3f));
    expect_val(2'd3, 16'h0000);
    @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    // parallel mode after reset: transparent latch, zero inputs
    expect_val(2'd0, gexp(6'h00));
    expect_val(2'd1, gexp(6'h00));
    @(posedge clk_sys_i);
    pw_a <= 1'b1;
    pw_b <= 1'b1;
    md <= 2'b01;
    repeat (8) @(posedge clk_sys_i);
    expect_val(2'd3, 16'h0003);
    w = rnd() & 16'h7fff;
    wa = w;
    u_host.xfer(2'b10, w, 16, 1'b0);
    expect_val(2'd0, gexp(w[5:0]));
    expect_val(2'd1, gexp(6'h3f));
    for (s = 0; s < 4; s++)
    begin
      r = rnd();
      w = {1'b0, r[14:8], s[1:0], r[5:0]};
      wa = w;
      g = r[5:0];
      u_host.xfer(2'b00, w, 16, 1'b0);
      expect_val(2'd0, gexp(g));
      expect_val(2'd1, gexp(g));
      t = g + (4 << s);
      t = (t > 63) ? 63 : t;
      {atk_b, atk_a} <= s[0] ? 2'b10 : 2'b01;
      repeat (10) @(posedge clk_sys_i);
      expect_val({1'b0, s[0]}, gexp(t[5:0]));
      expect_val({1'b0, !s[0]}, gexp(g));
      @(posedge clk_sys_i);
      {atk_b, atk_a} <= 2'b00;
      repeat (10) @(posedge clk_sys_i);
    end
    u_host.xfer(2'b10, 16'h0000, 15, 1'b0);
    expect_val(2'd0, gexp(g));
    u_host.xfer(2'b10, rnd() | 16'h8000, 16, 1'b0);
    expect_val(2'd0, gexp(g));
    u_host.xfer(2'b10, 16'h0000, 16, 1'b1);
    expect_val(2'd2, {1'b0, wa[14:0]});
    w = rnd() & 16'h7fff;
    wa = w;
    u_host.xfer(2'b10, w, 16, 1'b0);
    expect_val(2'd0, gexp(w[5:0]));
    // channel b alone, with a word that differs from channel a
    wb = ~w & 16'h7fff;
    u_host.xfer(2'b01, wb, 16, 1'b0);
    expect_val(2'd1, gexp(wb[5:0]));
    expect_val(2'd0, gexp(wa[5:0]));
    u_host.xfer(2'b01, rnd() | 16'h8000, 16, 1'b0);
    u_host.xfer(2'b01, 16'h0000, 16, 1'b1);
    expect_val(2'd2, wb);
    // a read request with both selects low is answered by channel a
    u_host.xfer(2'b00, 16'hffff, 16, 1'b0);
    expect_val(2'd1, gexp(wb[5:0]));
    u_host.xfer(2'b10, 16'h0000, 16, 1'b1);
    expect_val(2'd2, wa);
    md <= 2'b00;
    @(posedge clk_sys_i);
    r = rnd();
    pl_a <= 1'b0;
    pl_b <= 1'b0;
    pg_a <= r[5:0];
    pg_b <= r[11:6];
    repeat (10) @(posedge clk_sys_i);
    expect_val(2'd0, gexp(r[5:0]));
    expect_val(2'd1, gexp(r[11:6]));
    @(posedge clk_sys_i);
    pl_a <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    pg_a <= ~r[5:0];
    pw_b <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    expect_val(2'd0, gexp(r[5:0]));
    expect_val(2'd3, 16'h0001);
    // up/down stepping: one pin edge per step, clamped at the code 3f end, then one step up from it
    md <= 2'b10;
    repeat (4) @(posedge clk_sys_i);
    us <= 2'b11;
    ud_a <= 1'b0;
    uc_a <= ~uc_a;
    repeat (8) @(posedge clk_sys_i);
    expect_val(2'd0, gexp(6'h3f));
    md <= 2'b11;
    us <= 2'b10;
    ud_a <= 1'b1;
    uc_a <= ~uc_a;
    repeat (8) @(posedge clk_sys_i);
    expect_val(2'd0, gexp(6'h3b));
    expect_val(2'd1, gexp(6'h3f));
    repeat (2) @(posedge clk_sys_i);
    wrap_up();
  end
endmodule // vgsc_top_tb
